//--- design/power_mode_ctrl.sv
// Power-mode controller: run-source selection, idle and sleep clock gating, wake-up.
// Assumes software drives the request pins synchronously; oscillator ready flags are async.
//
// Summary of operation
// - Idle and sleep both gate off the CPU clock.
// - Idle on primary oscillator keeps source running and enabled peripherals clocked.
// - Idle may use fast, divided fast, secondary or low-power source; peripherals clocked.
// - Sleep halts CPU, stops selected system source unless it is low-power, and peripherals fed from it.
// - Running CPU clock selectable among fast, divided fast, low-power, secondary sources.
// - Peripheral bus clock is a programmable fraction of the system clock.
// - Clock-failure monitor is off throughout sleep.
// - Enabled supply-drop reset detector stays active in sleep.
// - Sleep entry does not clear the watchdog counter; it keeps counting.
// - Sleep exit waits a delay set by the selected oscillator.
// - Pin change, watchdog, converter, serial and externally clocked peripherals run in sleep.
// - Pad drive stays exactly as in normal operation during sleep.
// - Each peripheral can be disabled by software, also before sleep.
// - Live peripherals in sleep can raise a wake event ending sleep.
`timescale 1ns/1ps
`default_nettype none
module power_mode_ctrl (
  // Clock and reset
  input  wire logic                                   ref_clk,
  input  wire logic                                   sys_rst,
  // Software controls
  input  wire logic [2:0]                             run_src_sel,
  input  wire logic [1:0]                             pbus_ratio,
  input  wire logic                                   sleep_select,
  input  wire logic                                   power_down_req,
  input  wire logic [power_mode_pkg::NUM_PERIPH-1:0]  periph_disable,
  input  wire logic                                   supply_drop_enable,
  input  wire logic                                   watchdog_enable,
  input  wire logic                                   fail_monitor_enable,
  // Wake events and oscillator status
  input  wire logic [power_mode_pkg::NUM_PERIPH-1:0]  wake_event,
  input  wire logic [power_mode_pkg::NUM_OSC-1:0]     osc_ready,
  // Pad drive from the port logic
  input  wire logic [7:0]                             pad_oe_in,
  input  wire logic [7:0]                             pad_out_in,
  // Clock gating outputs
  output logic                                        cpu_clk_en,
  output logic [2:0]                                  system_clock_sel,
  output logic [power_mode_pkg::NUM_OSC-1:0]          osc_enable,
  output logic [power_mode_pkg::NUM_PERIPH-1:0]       periph_clk_en,
  output logic                                        peripheral_bus_clock_en,
  // Monitors
  output logic                                        clock_failure_monitor_en,
  output logic                                        supply_drop_reset_en,
  output logic                                        watchdog_counter_run,
  // Status and pads
  output logic [1:0]                                  power_state,
  output logic [7:0]                                  pad_oe,
  output logic [7:0]                                  pad_out
);

  // Maps a source code to its oscillator one-hot; used for enables and readiness
  function automatic logic [power_mode_pkg::NUM_OSC-1:0] src_osc(input logic [2:0] src);
    logic [power_mode_pkg::NUM_OSC-1:0] v;
    v = '0;
    unique case (src)
      power_mode_pkg::SRC_PRIMARY:   v[power_mode_pkg::OSC_PRIMARY]   = 1'b1;
      power_mode_pkg::SRC_FAST,
      power_mode_pkg::SRC_FAST_DIV:  v[power_mode_pkg::OSC_FAST]      = 1'b1;
      power_mode_pkg::SRC_SECONDARY: v[power_mode_pkg::OSC_SECONDARY] = 1'b1;
      default:                       v[power_mode_pkg::OSC_LOW_POWER] = 1'b1;
    endcase
    return v;
  endfunction : src_osc

  function automatic logic [11:0] wake_cycles(input logic [2:0] src);
    logic [11:0] c;
    c = power_mode_pkg::WAKE_LOW_POWER_CYC;
    unique case (src)
      power_mode_pkg::SRC_PRIMARY:   c = power_mode_pkg::WAKE_PRIMARY_CYC;
      power_mode_pkg::SRC_FAST,
      power_mode_pkg::SRC_FAST_DIV:  c = power_mode_pkg::WAKE_FAST_CYC;
      power_mode_pkg::SRC_SECONDARY: c = power_mode_pkg::WAKE_SECONDARY_CYC;
      default:                       c = power_mode_pkg::WAKE_LOW_POWER_CYC;
    endcase
    return c;
  endfunction : wake_cycles

  power_mode_pkg::pm_state_t                state_ff;
  power_mode_pkg::pm_state_t                nxt_state;
  logic [2:0]                               src_ff;
  logic [11:0]                              wake_cnt_ff;
  logic [11:0]                              nxt_wake_cnt;
  logic [power_mode_pkg::NUM_OSC-1:0]       ready_meta_ff;
  logic [power_mode_pkg::NUM_OSC-1:0]       ready_sync_ff;
  logic                                     cpu_clk_en_ff;
  logic [power_mode_pkg::NUM_OSC-1:0]       osc_enable_ff;
  logic [power_mode_pkg::NUM_PERIPH-1:0]    periph_clk_en_ff;
  logic                                     fail_mon_ff;
  logic                                     supply_drop_ff;
  logic                                     watchdog_ff;
  logic [7:0]                               pad_oe_ff;
  logic [7:0]                               pad_out_ff;

  pbus_div_if pbus ();

  // Decoding
  wire in_sleep    = (state_ff == power_mode_pkg::ST_SLEEP);
  wire in_wake     = (state_ff == power_mode_pkg::ST_WAKE);
  wire nxt_sleep   = (nxt_state == power_mode_pkg::ST_SLEEP);
  wire nxt_dark    = nxt_sleep || (nxt_state == power_mode_pkg::ST_WAKE);
  wire src_ready   = |(src_osc(src_ff) & ready_sync_ff);
  wire wake_delay_done = (wake_cnt_ff == 12'h0000);
  // Only peripherals still clocked in sleep can end it
  wire sleep_wake  = |(wake_event & power_mode_pkg::KEEP_ALIVE_MASK & ~periph_disable);
  wire idle_wake   = |(wake_event & ~periph_disable);
  wire valid_src   = (run_src_sel <= power_mode_pkg::SRC_LOW_POWER);

  // Leaving run happens only on the software request
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      power_mode_pkg::ST_RUN:
        if (power_down_req) begin
          nxt_state = sleep_select ? power_mode_pkg::ST_SLEEP : power_mode_pkg::ST_IDLE;
        end
      power_mode_pkg::ST_IDLE:
        if (idle_wake) begin
          nxt_state = power_mode_pkg::ST_RUN;
        end
      power_mode_pkg::ST_SLEEP:
        if (sleep_wake) begin
          nxt_state = power_mode_pkg::ST_WAKE;
        end
      power_mode_pkg::ST_WAKE:
        if (src_ready && wake_delay_done) begin
          nxt_state = power_mode_pkg::ST_RUN;
        end
    endcase
  end

  assign nxt_wake_cnt = in_sleep ? wake_cycles(src_ff)
                      : (wake_delay_done ? 12'h0000 : 12'(wake_cnt_ff - 12'h0001));

  // Peripheral gating: software disable always wins; sleep stops all but live ones
  logic [power_mode_pkg::NUM_PERIPH-1:0] nxt_periph_en;
  for (genvar i = 0; i < power_mode_pkg::NUM_PERIPH; i++) begin : g_periph
    assign nxt_periph_en[i] = !periph_disable[i] &&
                              (!nxt_dark || power_mode_pkg::KEEP_ALIVE_MASK[i]);
  end

  // Low-power oscillator never stops; it feeds watchdog and live peripherals
  wire [power_mode_pkg::NUM_OSC-1:0] nxt_osc_en =
    (nxt_sleep ? '0 : src_osc(src_ff)) | (4'h1 << power_mode_pkg::OSC_LOW_POWER);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff         <= power_mode_pkg::ST_RUN;
      src_ff           <= power_mode_pkg::SRC_RESET;
      wake_cnt_ff      <= 12'h0000;
      ready_meta_ff    <= '0;
      ready_sync_ff    <= '0;
      cpu_clk_en_ff    <= 1'b1;
      osc_enable_ff    <= '1;
      periph_clk_en_ff <= '0;
      fail_mon_ff      <= 1'b0;
      supply_drop_ff   <= 1'b0;
      watchdog_ff      <= 1'b0;
      pad_oe_ff        <= 8'h00;
      pad_out_ff       <= 8'h00;
    end else begin
      state_ff         <= nxt_state;
      wake_cnt_ff      <= nxt_wake_cnt;
      ready_meta_ff    <= osc_ready;
      ready_sync_ff    <= ready_meta_ff;
      // Source changes only while running, so wake always restarts what sleep stopped
      if (state_ff == power_mode_pkg::ST_RUN && valid_src) begin
        src_ff <= run_src_sel;
      end
      cpu_clk_en_ff    <= (nxt_state == power_mode_pkg::ST_RUN);
      osc_enable_ff    <= nxt_osc_en;
      periph_clk_en_ff <= nxt_periph_en;
      fail_mon_ff      <= fail_monitor_enable && !nxt_dark;
      supply_drop_ff   <= supply_drop_enable;
      watchdog_ff      <= watchdog_enable;
      pad_oe_ff        <= pad_oe_in;
      pad_out_ff       <= pad_out_in;
    end
  end

  // Bus clock follows the system clock, so it stops with it in sleep
  assign pbus.ratio = pbus_ratio;
  assign pbus.run   = !in_sleep && !in_wake;

  pbus_clock_divider u_pbus_div (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .link    (pbus.div)
  );

  assign cpu_clk_en               = cpu_clk_en_ff;
  assign system_clock_sel         = src_ff;
  assign osc_enable               = osc_enable_ff;
  assign periph_clk_en            = periph_clk_en_ff;
  assign peripheral_bus_clock_en  = pbus.tick;
  assign clock_failure_monitor_en = fail_mon_ff;
  assign supply_drop_reset_en     = supply_drop_ff;
  assign watchdog_counter_run     = watchdog_ff;
  assign power_state              = state_ff;
  assign pad_oe                   = pad_oe_ff;
  assign pad_out                  = pad_out_ff;

  cpu_gated_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_ff == power_mode_pkg::ST_IDLE || in_sleep) |-> !cpu_clk_en_ff)
    else $error("CPU clock running while halted");

  request_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_ff == power_mode_pkg::ST_RUN && power_down_req && sleep_select) |=>
      (in_sleep && !cpu_clk_en_ff))
    else $error("sleep request not taken");

  idle_source_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_ff == power_mode_pkg::ST_IDLE && $past(state_ff) == power_mode_pkg::ST_IDLE)
      |-> |(osc_enable_ff & src_osc(src_ff)))
    else $error("system source stopped in idle");

  sleep_source_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (in_sleep && src_ff != power_mode_pkg::SRC_LOW_POWER) |-> !(|(osc_enable_ff & src_osc(src_ff))))
    else $error("system source running in sleep");

  sleep_periph_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_sleep |-> ((periph_clk_en_ff & ~power_mode_pkg::KEEP_ALIVE_MASK) == 8'h00))
    else $error("system-clocked peripheral running in sleep");

  no_self_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_ff == power_mode_pkg::ST_RUN && !power_down_req) |=> state_ff == power_mode_pkg::ST_RUN)
    else $error("power mode entered without request");

  monitor_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_sleep |-> !fail_mon_ff)
    else $error("clock failure monitor active in sleep");

  wake_gated_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (in_wake && !src_ready) |=> !cpu_clk_en_ff)
    else $error("CPU released before source stable");

  wake_delay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (in_sleep ##1 in_wake) |-> !cpu_clk_en_ff [*8])
    else $error("wake delay too short");

  wake_event_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (in_sleep && sleep_wake) |=> in_wake)
    else $error("wake event ignored in sleep");

endmodule : power_mode_ctrl
`default_nettype wire

//--- design/power_mode_pkg.sv
// Constants and types shared by the power-mode controller and its testbench.
// Assumes a single 10 MHz reference clock and a synchronous active-high reset.
`default_nettype none
package power_mode_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NUM_PERIPH    = 8;
  localparam int unsigned NUM_OSC       = 4;

  // Oscillator enable vector positions
  localparam int unsigned OSC_PRIMARY   = 0;
  localparam int unsigned OSC_FAST      = 1;
  localparam int unsigned OSC_SECONDARY = 2;
  localparam int unsigned OSC_LOW_POWER = 3;

  // Peripherals clocked from a pin or the low-power oscillator; they live on in sleep.
  // Bit 0 calendar_clock, 1 first timer, 2 input capture, 3 pin change detect,
  // 4 converter, 5 serial port.
  localparam logic [7:0] KEEP_ALIVE_MASK = 8'h3F;

  // Oscillator restart times after sleep, in ns, and derived cycle counts (least, so round up)
  localparam int unsigned WAKE_PRIMARY_NS   = 100_000;
  localparam int unsigned WAKE_FAST_NS      = 10_000;
  localparam int unsigned WAKE_SECONDARY_NS = 200_000;
  localparam int unsigned WAKE_LOW_POWER_NS = 20_000;
  localparam logic [11:0] WAKE_PRIMARY_CYC   =
    12'((WAKE_PRIMARY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] WAKE_FAST_CYC      =
    12'((WAKE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] WAKE_SECONDARY_CYC =
    12'((WAKE_SECONDARY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] WAKE_LOW_POWER_CYC =
    12'((WAKE_LOW_POWER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [2:0] SRC_RESET   = 3'h1;
  localparam logic [1:0] RATIO_RESET = 2'h0;

  typedef enum logic [2:0] {
    SRC_PRIMARY   = 3'h0,
    SRC_FAST      = 3'h1,
    SRC_FAST_DIV  = 3'h2,
    SRC_SECONDARY = 3'h3,
    SRC_LOW_POWER = 3'h4
  } clk_src_t;

  // Gray along run -> sleep -> wake; wake -> run flips both bits; idle one step from run
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_SLEEP = 2'h1,
    ST_WAKE  = 2'h3,
    ST_IDLE  = 2'h2
  } pm_state_t;

endpackage : power_mode_pkg
`default_nettype wire

//--- design/pbus_div_if.sv
// Carrier between the power-mode controller and its peripheral bus clock divider.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface pbus_div_if;
  logic [1:0] ratio;
  logic       run;
  logic       tick;
  modport ctrl (output ratio, output run, input tick);
  modport div  (input ratio, input run, output tick);
endinterface : pbus_div_if
`default_nettype wire

//--- design/pbus_clock_divider.sv
// Peripheral bus clock enable: one tick every 1, 2, 4 or 8 system clocks.
// Assumes ratio changes only between ticks are tolerable; count restarts when stopped.
`timescale 1ns/1ps
`default_nettype none
module pbus_clock_divider (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Controller side
  pbus_div_if.div   link
);

  logic [2:0] count_ff;
  logic       tick_ff;
  wire  [2:0] limit    = 3'((4'h1 << link.ratio) - 4'h1);
  wire        wrap     = (count_ff >= limit);
  wire  [2:0] nxt_count = wrap ? 3'h0 : 3'(count_ff + 3'h1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !link.run) begin
      count_ff <= 3'h0;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff  <= wrap;
    end
  end

  assign link.tick = tick_ff;

  tick_spacing_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (link.run && link.ratio == 2'h1 && $past(link.run) && $past(link.ratio) == 2'h1 && tick_ff)
      |=> !tick_ff)
    else $error("bus tick repeated at half rate");

endmodule : pbus_clock_divider
`default_nettype wire

//--- testbench/osc_source_model.sv
// Oscillator model: each enabled oscillator reports stable after a settable start-up time.
// Assumes ref_clk and sys_rst of the controller; ready drops at once when disabled.
`timescale 1ns/1ps
`default_nettype none
module osc_source_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Controller side
  input  wire logic [3:0]  osc_enable,
  input  wire logic [11:0] start_cycles,
  output logic      [3:0]  osc_ready
);
  logic [11:0] run_cnt_ff [4];

  // Start-up count restarts whenever the oscillator is stopped
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (sys_rst || !osc_enable[i]) begin
        run_cnt_ff[i] <= 12'h000;
      end else if (run_cnt_ff[i] != 12'hFFF) begin
        run_cnt_ff[i] <= run_cnt_ff[i] + 12'h001;
      end
    end
  end

  // A large start_cycles makes a slow oscillator that outlasts the wake delay
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      osc_ready[i] = osc_enable[i] && (run_cnt_ff[i] >= start_cycles);
    end
  end
endmodule : osc_source_model
`default_nettype wire

//--- testbench/power_mode_clock_gating_tb_top.sv
// Self-checking bench for the power-mode controller with an oscillator model.
// Assumes a 10 MHz ref_clk; inputs change at the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_gating_tb_top;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  run_src_sel = 3'h1;
  logic [1:0]  pbus_ratio = 2'h0;
  logic        sleep_select = 1'b0, power_down_req = 1'b0;
  logic        supply_drop_enable = 1'b0, watchdog_enable = 1'b0, fail_monitor_enable = 1'b0;
  logic [7:0]  periph_disable = 8'h00, wake_event = 8'h00, pad_oe_in = 8'h00, pad_out_in = 8'h00;
  logic [3:0]  osc_ready, osc_enable;
  logic [11:0] start_cycles = 12'h005;
  logic        cpu_clk_en, peripheral_bus_clock_en, clock_failure_monitor_en;
  logic        supply_drop_reset_en, watchdog_counter_run;
  logic [2:0]  system_clock_sel;
  logic [7:0]  periph_clk_en, pad_oe, pad_out;
  logic [1:0]  power_state;
  int          miscompares = 0;
  int          checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  power_mode_ctrl u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .run_src_sel(run_src_sel), .pbus_ratio(pbus_ratio),
    .sleep_select(sleep_select), .power_down_req(power_down_req),
    .periph_disable(periph_disable), .supply_drop_enable(supply_drop_enable),
    .watchdog_enable(watchdog_enable), .fail_monitor_enable(fail_monitor_enable),
    .wake_event(wake_event), .osc_ready(osc_ready), .pad_oe_in(pad_oe_in),
    .pad_out_in(pad_out_in), .cpu_clk_en(cpu_clk_en), .system_clock_sel(system_clock_sel),
    .osc_enable(osc_enable), .periph_clk_en(periph_clk_en),
    .peripheral_bus_clock_en(peripheral_bus_clock_en),
    .clock_failure_monitor_en(clock_failure_monitor_en),
    .supply_drop_reset_en(supply_drop_reset_en), .watchdog_counter_run(watchdog_counter_run),
    .power_state(power_state), .pad_oe(pad_oe), .pad_out(pad_out)
  );

  osc_source_model u_osc (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .osc_enable(osc_enable),
    .start_cycles(start_cycles), .osc_ready(osc_ready)
  );

  task automatic complete_run();
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic chk_span(input int got, input int lo, input int hi, input string msg);
    checks_done++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("MISMATCH t=%0t %s took %0d not in %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask : chk_span

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Software request pulse; returns after the taking edge has updated the state
  task automatic request(input logic to_sleep);
    sleep_select = to_sleep;
    power_down_req = 1'b1;
    cyc(1);
    power_down_req = 1'b0;
  endtask : request

  function automatic logic [3:0] osc_of(input logic [2:0] src);
    case (src)
      3'h0: return 4'h1;
      3'h1, 3'h2: return 4'h2;
      3'h3: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : osc_of

  function automatic int wake_of(input logic [2:0] src);
    case (src)
      3'h0: return int'(power_mode_pkg::WAKE_PRIMARY_CYC);
      3'h1, 3'h2: return int'(power_mode_pkg::WAKE_FAST_CYC);
      3'h3: return int'(power_mode_pkg::WAKE_SECONDARY_CYC);
      default: return int'(power_mode_pkg::WAKE_LOW_POWER_CYC);
    endcase
  endfunction : wake_of

  // Watchdog: full run needs well under 20000 cycles
  initial begin
    #2_000_000;
    miscompares++;
    complete_run();
  end

  initial begin
    logic [2:0] sel;
    int         n;
    void'($urandom(12936));
    cyc(16);
    chk({2'h0, cpu_clk_en, system_clock_sel, osc_enable, power_state},
        {2'h0, 1'b1, power_mode_pkg::SRC_RESET, 4'hF, 2'h0}, "reset state");
    chk({4'h0, periph_clk_en}, 12'h000, "reset periph");
    sys_rst = 1'b0;
    sel = 3'h1;
    // Wake events without a request must not leave run
    repeat (20) begin
      wake_event = 8'($urandom);
      cyc(1);
      chk({10'h000, power_state}, 12'h000, "no request");
    end
    wake_event = 8'h00;
    for (int c = 7; c >= 0; c--) begin
      run_src_sel = 3'(c);
      periph_disable = 8'($urandom);
      supply_drop_enable = 1'($urandom);
      sel = (c <= 4) ? 3'(c) : sel;
      cyc(3);
      chk({9'h000, system_clock_sel}, {9'h000, sel}, "run source");
      chk({4'h0, periph_clk_en}, {4'h0, ~periph_disable}, "run periph");
      chk({11'h000, supply_drop_reset_en}, {11'h000, supply_drop_enable}, "bor run");
    end
    for (int r = 0; r < 4; r++) begin
      pbus_ratio = 2'(r);
      cyc(16);
      n = 0;
      repeat (64) begin
        cyc(1);
        n += int'(peripheral_bus_clock_en);
      end
      chk(12'(n), 12'(64 >> r), "bus ratio");
    end
    for (int s = 0; s < 5; s++) begin
      run_src_sel = 3'(s);
      periph_disable = 8'($urandom) & 8'hFE;
      cyc(3);
      request(1'b0);
      chk({2'h0, cpu_clk_en, system_clock_sel, osc_enable, power_state},
          {2'h0, 1'b0, 3'(s), osc_of(3'(s)) | 4'h8, 2'h2}, "idle entry");
      chk({4'h0, periph_clk_en}, {4'h0, ~periph_disable}, "idle periph");
      cyc(1);
      request(1'b1);
      chk({10'h000, power_state}, 12'h002, "request in idle");
      wake_event = 8'h01;
      cyc(1);
      wake_event = 8'h00;
      chk({11'h000, cpu_clk_en}, 12'h001, "idle wake");
      chk({10'h000, power_state}, 12'h000, "idle exit");
    end
    for (int s = 0; s < 5; s++) begin
      run_src_sel = 3'(s);
      start_cycles = (s == 1) ? 12'h05DC : 12'(5 + $urandom_range(40));
      periph_disable = 8'($urandom) & 8'hFE;
      {supply_drop_enable, watchdog_enable, fail_monitor_enable} = 3'($urandom);
      cyc(3);
      chk({11'h000, clock_failure_monitor_en}, {11'h000, fail_monitor_enable}, "monitor run");
      request(1'b1);
      chk({10'h000, power_state}, 12'h001, "sleep entry");
      chk({7'h00, cpu_clk_en, osc_enable},
          {7'h00, 1'b0, osc_of(3'h4)}, "sleep clocks");
      chk({4'h0, periph_clk_en}, {4'h0, 8'h3F & ~periph_disable}, "sleep periph");
      chk({9'h000, clock_failure_monitor_en, supply_drop_reset_en, watchdog_counter_run},
          {9'h000, 1'b0, supply_drop_enable, watchdog_enable}, "monitors");
      chk({11'h000, watchdog_counter_run}, {11'h000, watchdog_enable}, "watchdog");
      pad_oe_in = 8'($urandom);
      pad_out_in = 8'($urandom);
      n = 0;
      repeat (8) begin
        cyc(1);
        n += int'(peripheral_bus_clock_en);
      end
      chk({pad_oe, 4'h0}, {pad_oe_in, 4'h0}, "pad enable");
      chk({pad_out, 4'h0}, {pad_out_in, 4'h0}, "pad drive");
      chk(12'(n), 12'h000, "bus in sleep");
      wake_event = 8'h80;
      cyc(1);
      chk({10'h000, power_state}, 12'h001, "dead wake");
      wake_event = 8'h01;
      cyc(1);
      wake_event = 8'h00;
      chk({3'h0, cpu_clk_en, 6'h00, power_state}, 12'h003, "wake start");
      n = 1;
      while (power_state !== 2'h0 && n < 3000) begin
        cyc(1);
        n++;
        if (power_state !== 2'h0) begin
          chk({11'h000, cpu_clk_en}, 12'h000, "gated in wake");
        end
      end
      chk_span(n, wake_of(3'(s)) - 2,
               ((wake_of(3'(s)) > int'(start_cycles)) ? wake_of(3'(s)) : int'(start_cycles)) + 8,
               "wake delay");
      chk({7'h00, cpu_clk_en, osc_enable},
          {7'h00, 1'b1, osc_of(3'(s)) | 4'h8}, "wake done");
    end
    complete_run();
  end
endmodule : power_mode_clock_gating_tb_top
`default_nettype wire
